/* File: rtl/xad_decoder.sv */
`timescale 1ns/1ps

module xad_decoder #(
  parameter int NUM_WIN = 4                 // external window registers
) (
  input  wire logic              clk,              // cpu clock
  input  wire logic              rst,              // async reset, high
  input  wire xad_pkg::xad_req_t req,              // cpu access
  input  wire logic              global_xbus_enable, // system config bit
  input  wire logic [15:0]       xbus_peripheral_config, // per-target
  input  wire logic              lrw_load,         // load window select
  input  wire logic [7:0]        lrw_value,        // window, 64K units
  input  wire logic              bootstrap_mode,   // pin strap
  input  wire logic [NUM_WIN*24-1:0] ext_window_select_n, // bases
  input  wire logic [NUM_WIN*24-1:0] ext_window_mask_n,   // masks
  output xad_pkg::xad_sel_t      sel,              // registered decode
  output logic [7:0]             large_ram_window_select, // current
  output logic                   ext_limited,      // 5M external only
  output logic [15:0]            periph_visible    // claimed targets
);

  // ==========================================================
  // strap and enable capture
  // ==========================================================
  logic boot_s1_r;                          // synchroniser stage 1
  logic boot_s2_r;                          // synchroniser stage 2
  logic xen_s1_r;                           // xbus enable stage 1
  logic xen_s2_r;                           // xbus enable stage 2

  // pin strap and enable treated as asynchronous levels
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      boot_s1_r <= 1'b0;
      boot_s2_r <= 1'b0;
      xen_s1_r  <= 1'b0;
      xen_s2_r  <= 1'b0;
    end else begin
      boot_s1_r <= bootstrap_mode;
      boot_s2_r <= boot_s1_r;
      xen_s1_r  <= global_xbus_enable;
      xen_s2_r  <= xen_s1_r;
    end
  end

  // ==========================================================
  // large ram window register
  // ==========================================================
  localparam logic [7:0] LRW_RST = xad_pkg::LRAM_WIN_RST[23:16];

  // software moves the window; reset puts it at segment 9
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      large_ram_window_select <= LRW_RST;
    end else if (lrw_load) begin
      large_ram_window_select <= lrw_value;
    end
  end

  // ==========================================================
  // enable qualification
  // ==========================================================
  logic [15:0] en;                          // per-bit effective enable

  // a clear bit means the page stays unclaimed and invisible
  assign en = xen_s2_r ? xbus_peripheral_config : 16'h0000;

  assign periph_visible = en;

  // can pins take segment lines away from external memory
  assign ext_limited = en[xad_pkg::PC_CAN1] | en[xad_pkg::PC_CAN2];

  // ==========================================================
  // address decode
  // ==========================================================
  logic [23:0]          a;                  // request address
  logic [15:0]          page;               // address bits 23:8
  xad_pkg::xad_target_t tgt;                // combinational target
  logic [23:0]          taddr;              // address forwarded
  logic [1:0]           twait;              // wait states
  logic                 tdemux;             // demux bus
  logic                 terr;               // refused form
  logic                 in_lrw;             // inside large window
  logic [2:0]           win;                // external window hit

  assign a    = req.addr;
  assign page = a[23:8];
  // window is 64K wide; 8K ram mirrored each 16K inside it
  assign in_lrw = (a[23:16] == large_ram_window_select)
                & (a[13:0] < xad_pkg::LRAM_SIZE[13:0]);

  // external window match, first hit wins
  always_comb begin
    win = 3'h0;
    for (int i = NUM_WIN - 1; i >= 0; i--) begin
      if (((a ^ ext_window_select_n[i*24 +: 24])
           & ext_window_mask_n[i*24 +: 24]) == 24'h00_0000) begin
        win = 3'(i + 1);
      end
    end
  end

  // priority: xbus pages, rams, flash, else external
  always_comb begin
    tgt    = xad_pkg::XAD_T_EXT;
    taddr  = a;
    twait  = xad_pkg::XRAM_WAIT;
    tdemux = 1'b0;
    terr   = 1'b0;
    if (page == xad_pkg::PG_CAN1 && en[xad_pkg::PC_CAN1]) begin
      tgt = xad_pkg::XAD_T_CAN1;
    end else if (page == xad_pkg::PG_CAN2 && en[xad_pkg::PC_CAN2]) begin
      tgt = xad_pkg::XAD_T_CAN2;
    end else if (page == xad_pkg::PG_RTC && en[xad_pkg::PC_RTC]) begin
      tgt = xad_pkg::XAD_T_RTC;
    end else if (page == xad_pkg::PG_PWM && en[xad_pkg::PC_PWM]) begin
      tgt = xad_pkg::XAD_T_PWM;
    end else if (page == xad_pkg::PG_ASC && en[xad_pkg::PC_ASC]) begin
      tgt = xad_pkg::XAD_T_ASC;
    end else if (page == xad_pkg::PG_SSC && en[xad_pkg::PC_SSC]) begin
      tgt = xad_pkg::XAD_T_SSC;
    end else if (page == xad_pkg::PG_I2C && en[xad_pkg::PC_I2C]) begin
      tgt = xad_pkg::XAD_T_I2C;
    end else if (page == xad_pkg::PG_MISC && en[xad_pkg::PC_MISC]) begin
      tgt = xad_pkg::XAD_T_MISC;
    end else if (a >= xad_pkg::SRAM_BASE && a <= xad_pkg::SRAM_LAST
                 && en[xad_pkg::PC_SMALL_RAM]) begin
      tgt = xad_pkg::XAD_T_SRAM;
    end else if (in_lrw && en[xad_pkg::PC_LARGE_RAM]) begin
      tgt   = xad_pkg::XAD_T_LRAM;
      // fold mirrors onto the 8K array offset
      taddr = {11'h000, a[12:0]};
    end else if (boot_s2_r && a <= xad_pkg::TF_LAST) begin
      tgt = xad_pkg::XAD_T_TFL;
    end else if (a <= xad_pkg::FL_LOW_LAST
                 || (a >= xad_pkg::FL_S4_BASE
                     && a <= xad_pkg::FL_S5_LAST)) begin
      tgt = xad_pkg::XAD_T_FLASH;
    end else if (a > xad_pkg::FL_S5_LAST
                 && a <= xad_pkg::FL_RSV_LAST) begin
      tgt = xad_pkg::XAD_T_RSV;
    end
    // disabled ram ranges fall through to external above

    // access form per target class
    unique case (tgt)
      xad_pkg::XAD_T_SRAM,
      xad_pkg::XAD_T_LRAM: begin
        tdemux = 1'b1;
        twait  = xad_pkg::XRAM_WAIT;
        // no stack, bank or bit storage here
        terr   = req.bit_op | req.stack;
      end
      xad_pkg::XAD_T_CAN1,
      xad_pkg::XAD_T_CAN2: begin
        tdemux = 1'b1;
        twait  = xad_pkg::XPER_WAIT;
        terr   = req.byte_en;
      end
      xad_pkg::XAD_T_RTC,
      xad_pkg::XAD_T_PWM,
      xad_pkg::XAD_T_ASC,
      xad_pkg::XAD_T_SSC,
      xad_pkg::XAD_T_I2C,
      xad_pkg::XAD_T_MISC: begin
        tdemux = 1'b1;
        twait  = xad_pkg::XPER_WAIT;
        terr   = req.byte_en;
      end
      xad_pkg::XAD_T_EXT: begin
        // top segment lines missing while can is in use
        terr = ext_limited && (a > xad_pkg::EXT_CAN_LAST);
      end
      xad_pkg::XAD_T_FLASH,
      xad_pkg::XAD_T_TFL,
      xad_pkg::XAD_T_RSV: begin
        terr = 1'b0;
      end
      default: begin
        terr = 1'b1;
      end
    endcase
  end

  // ==========================================================
  // registered output
  // ==========================================================
  // one cycle of decode latency keeps the compare tree off the bus path
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sel <= '0;
    end else begin
      sel.valid   <= req.valid;
      sel.target  <= tgt;
      sel.addr    <= taddr;
      sel.waits   <= twait;
      sel.demux   <= tdemux;
      sel.err     <= req.valid & terr;
      sel.ext_win <= (tgt == xad_pkg::XAD_T_EXT) ? win : 3'h0;
    end
  end

endmodule

/* File: rtl/xad_pkg.sv */
package xad_pkg;

  // ==========================================================
  // address space
  // ==========================================================
  localparam int          ADDR_W         = 24;      // 16-Mbyte linear space
  localparam int          DATA_W         = 16;      // internal data width

  // small extension ram window
  localparam logic [23:0] SRAM_BASE      = 24'h00_E000;
  localparam logic [23:0] SRAM_LAST      = 24'h00_E7FF;

  // large extension ram: 8 Kbyte, mirrored every 16 Kbyte
  localparam logic [23:0] LRAM_SIZE      = 24'h00_2000;
  localparam logic [23:0] LRAM_MIRROR    = 24'h00_4000;
  localparam logic [23:0] LRAM_WIN_RST   = 24'h09_0000; // window after reset
  localparam logic [23:0] LRAM_WIN_SIZE  = 24'h01_0000; // window span

  // xbus peripheral 256-byte pages (address bits 23:8)
  localparam logic [15:0] PG_CAN1        = 16'h00EF;
  localparam logic [15:0] PG_CAN2        = 16'h00EE;
  localparam logic [15:0] PG_RTC         = 16'h00ED;
  localparam logic [15:0] PG_PWM         = 16'h00EC;
  localparam logic [15:0] PG_MISC        = 16'h00EB;
  localparam logic [15:0] PG_I2C         = 16'h00EA;
  localparam logic [15:0] PG_ASC         = 16'h00E9;
  localparam logic [15:0] PG_SSC         = 16'h00E8;

  // peripheral configuration bit positions
  localparam int          PC_SMALL_RAM   = 2;
  localparam int          PC_LARGE_RAM   = 3;
  localparam int          PC_CAN1        = 0;
  localparam int          PC_CAN2        = 1;
  localparam int          PC_RTC         = 4;
  localparam int          PC_PWM         = 6;
  localparam int          PC_ASC         = 7;
  localparam int          PC_SSC         = 8;
  localparam int          PC_I2C         = 9;
  localparam int          PC_MISC        = 10;

  // flash sectors in user mode
  localparam logic [23:0] FL_LOW_LAST    = 24'h00_7FFF; // sectors 0..3
  localparam logic [23:0] FL_S4_BASE     = 24'h01_8000;
  localparam logic [23:0] FL_S5_BASE     = 24'h02_0000;
  localparam logic [23:0] FL_S5_LAST     = 24'h02_FFFF;
  localparam logic [23:0] FL_RSV_LAST    = 24'h04_FFFF;
  localparam logic [23:0] TF_LAST        = 24'h00_1FFF; // test sector

  // external memory with can in use: 4 segment lines
  localparam logic [23:0] EXT_CAN_LAST   = 24'h4F_FFFF; // 5 Mbyte

  // ==========================================================
  // timing
  // ==========================================================
  localparam real         CPU_NS         = 5.0;     // clk period
  localparam real         XPER_ACC_NS    = 62.5;    // documented access
  localparam real         REF_CYC_NS     = 15.625;  // 64 MHz cycle
  localparam logic [1:0]  XPER_WAIT      = 2'h2;    // wait states
  localparam logic [1:0]  XRAM_WAIT      = 2'h0;

  // ==========================================================
  // target selection
  // ==========================================================
  typedef enum logic [3:0] {
    XAD_T_EXT   = 4'b0000,
    XAD_T_FLASH = 4'b0001,
    XAD_T_TFL   = 4'b0010,
    XAD_T_SRAM  = 4'b0011,
    XAD_T_LRAM  = 4'b0100,
    XAD_T_CAN1  = 4'b0101,
    XAD_T_CAN2  = 4'b0110,
    XAD_T_RTC   = 4'b0111,
    XAD_T_PWM   = 4'b1000,
    XAD_T_ASC   = 4'b1001,
    XAD_T_SSC   = 4'b1010,
    XAD_T_I2C   = 4'b1011,
    XAD_T_MISC  = 4'b1100,
    XAD_T_RSV   = 4'b1101
  } xad_target_t;

  // cpu request
  typedef struct packed {
    logic        valid;   // access request
    logic [23:0] addr;    // byte address
    logic        write;   // 1 = write
    logic        byte_en; // 1 = byte access
    logic        bit_op;  // single-bit access
    logic        stack;   // system stack / register bank use
  } xad_req_t;

  // decode result
  typedef struct packed {
    logic        valid;     // registered decode strobe
    xad_target_t target;    // selected target
    logic [23:0] addr;      // address to target (folded for large ram)
    logic [1:0]  waits;     // on-chip wait states
    logic        demux;     // demultiplexed 16-bit access
    logic        err;       // illegal access form, refused
    logic [2:0]  ext_win;   // external window index (0 = default)
  } xad_sel_t;

endpackage

/* File: tb/xad_decoder_assertions.sv */
`timescale 1ns/1ps
// ==========================================================
// decoder checker
// ==========================================================
module xad_decoder_assertions (
  input wire logic              clk,                     // cpu clock
  input wire logic              rst,                     // reset
  input wire xad_pkg::xad_req_t req,                     // access
  input wire logic              global_xbus_enable,      // xbus on
  input wire logic [15:0]       xbus_peripheral_config,  // enables
  input wire logic              bootstrap_mode,          // strap
  input wire xad_pkg::xad_sel_t sel,                     // decode
  input wire logic [7:0]        large_ram_window_select  // window
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (rst);
  logic [2:0]  xh_r; // enable history
  logic [2:0]  bh_r; // strap history
  logic        xon;  // enable settled high
  logic        v;    // valid request
  logic [23:0] a;    // request address
  logic [15:0] c;    // peripheral enables
  // enables cross two flops, so only settled values are judged
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      xh_r <= 3'h0;
      bh_r <= 3'h0;
    end else begin
      xh_r <= {xh_r[1:0], global_xbus_enable};
      bh_r <= {bh_r[1:0], bootstrap_mode};
    end
  end
  assign xon = &{xh_r, global_xbus_enable};
  assign v   = req.valid;
  assign a   = req.addr;
  assign c   = xbus_peripheral_config;
  a_can1_word: assert property (
    v && !req.byte_en && a[23:8] == 16'h00EF && c[0] && xon |=>
    sel.target == xad_pkg::XAD_T_CAN1 && sel.waits == 2'h2 && sel.demux
    && !sel.err) else $error("can word access misdecoded");
  a_can_byte_err: assert property (
    v && req.byte_en && a[23:8] == 16'h00EF && c[0] && xon |=> sel.err)
    else $error("can byte access not refused");
  a_small_ram: assert property (
    v && a[23:11] == 13'h001C && c[2] && xon && !req.bit_op && !req.stack
    |=> sel.target == xad_pkg::XAD_T_SRAM && sel.waits == 2'h0 && !sel.err)
    else $error("small ram access misdecoded");
  a_ram_bit_err: assert property (
    v && (req.bit_op || req.stack) && a[23:11] == 13'h001C && c[2] && xon
    |=> sel.err) else $error("bit or stack ram access not refused");
  a_large_ram: assert property (
    v && a[23:16] == large_ram_window_select && !a[13] && c[3] && xon |=>
    sel.target == xad_pkg::XAD_T_LRAM && sel.addr == ($past(a) & 24'h00_1FFF))
    else $error("large ram access misdecoded");
  a_off_external: assert property (
    v && ((~|{xh_r, global_xbus_enable} && (a[23:11] == 13'h001C
    || a[23:16] == large_ram_window_select)) || (xon && a[23:8] == 16'h00EF
    && !c[0])) |=> sel.target == xad_pkg::XAD_T_EXT)
    else $error("disabled target still claimed");
  a_can_ext_limit: assert property (
    v && a > 24'h4F_FFFF && a[23:16] != large_ram_window_select && xon && c[0]
    |=> sel.target == xad_pkg::XAD_T_EXT && sel.err)
    else $error("external access past limit not refused");
  a_flash_map: assert property (
    (v && a inside {[24'h03_0000:24'h04_FFFF]}
    |=> sel.target == xad_pkg::XAD_T_RSV)
    and (v && &{bh_r, bootstrap_mode} && a <= 24'h00_1FFF
    |=> sel.target == xad_pkg::XAD_T_TFL)) else $error("flash misdecoded");
  c_can1: cover property (v && a[23:8] == 16'h00EF && c[0] && xon);
  c_lram: cover property (v && a[23:16] == large_ram_window_select && c[3]);
  c_boot: cover property (v && &{bh_r, bootstrap_mode} && a == 24'h00_0000);
endmodule
bind xad_decoder xad_decoder_assertions chk_u (.clk, .rst, .req, .sel,
  .global_xbus_enable, .xbus_peripheral_config, .bootstrap_mode,
  .large_ram_window_select);

/* File: tb/xad_cpu_model.sv */
`timescale 1ns/1ps
// ==========================================================
// cpu bus master stand-in
// ==========================================================
module xad_cpu_model (
  input  wire logic         clk, // cpu clock
  output xad_pkg::xad_req_t req  // access to decoder
);
  initial req = '0; // idle from time zero
  // launched just after an edge, so the next edge samples it cleanly
  task automatic issue(input logic [23:0] a, input logic [3:0] k);
    @(posedge clk);
    #1;
    req = '{1'h1, a, k[3], k[2], k[1], k[0]};
  endtask
endmodule

/* File: tb/xbus_address_decoder_tb_top.sv */
`timescale 1ns/1ps
`define CHK(n, e, g) \
  begin \
    checks++; \
    if ((g) !== (e)) begin \
      fail_count++; \
      $display("unexpected %s exp %0h got %0h", n, e, g); \
    end \
  end
// ==========================================================
// decoder bench
// ==========================================================
module xbus_address_decoder_tb_top;
  logic              clk;                            // cpu clock
  logic              rst = 1'h1;                     // reset
  xad_pkg::xad_req_t req;                            // from cpu model
  logic              global_xbus_enable = 1'h0;      // xbus on
  logic [15:0]       xbus_peripheral_config = '0;    // enables
  logic              lrw_load = 1'h0;                // window load
  logic [7:0]        lrw_value = 8'h00;              // window value
  logic              bootstrap_mode = 1'h0;          // strap
  logic [95:0]       ext_window_select_n = {{3{24'hFF_FFFF}}, 24'h10_0000};
  logic [95:0]       ext_window_mask_n = {{3{24'hFF_FFFF}}, 24'hF0_0000};
  xad_pkg::xad_sel_t sel;                            // decode
  logic [7:0]        large_ram_window_select;        // window
  logic              ext_limited;                    // 5M limit
  logic [15:0]       periph_visible;                 // claimed
  int                fail_count = 0;                 // mismatches
  int                checks = 0;                     // comparisons
  logic [23:0]       ad;                             // loop address
  xad_pkg::xad_target_t t;                           // loop target
  // xbus pages in target order, with their enable bits
  logic [7:0]        pg [8] = '{8'hEF, 8'hEE, 8'hED, 8'hEC,
                                8'hE9, 8'hE8, 8'hEA, 8'hEB};
  int                bt [8] = '{0, 1, 4, 6, 7, 8, 9, 10};

  xad_cpu_model cpu_u (.clk, .req);
  xad_decoder #(.NUM_WIN(4)) dut_u (.clk, .rst, .req, .global_xbus_enable,
    .xbus_peripheral_config, .lrw_load, .lrw_value, .bootstrap_mode,
    .ext_window_select_n, .ext_window_mask_n, .sel,
    .large_ram_window_select, .ext_limited, .periph_visible);

  initial begin
    clk = 1'h0;
    forever #2.5 clk = ~clk;
  end

  task automatic tally_and_finish();
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // one access, decode judged at the first edge after it is launched
  task automatic acc(input logic [23:0] a, input logic [3:0] k,
                     input xad_pkg::xad_target_t tg, input logic e);
    cpu_u.issue(a, k);
    @(posedge clk);
    #1;
    `CHK("valid", 1'h1, sel.valid)
    `CHK("target", tg, sel.target)
    `CHK("err", e, sel.err)
  endtask

  // new enables; three edges cover the two-flop settling
  task automatic cfg(input logic x, input logic [15:0] c, input logic b);
    @(posedge clk);
    #1;
    global_xbus_enable = x;
    xbus_peripheral_config = c;
    bootstrap_mode = b;
    repeat (3) @(posedge clk);
  endtask

  // hang guard: the run needs under one microsecond
  initial begin
    #20000;
    fail_count++;
    tally_and_finish();
  end

  initial begin
    repeat (12) @(posedge clk);
    #1;
    rst = 1'h0;
    `CHK("window", 8'h09, large_ram_window_select)
    // each xbus target: claimed only by its own bit, word only
    for (int i = 0; i < 8; i++) begin
      ad = {8'h00, pg[i], 8'h10};
      t = xad_pkg::xad_target_t'(4'h5 + i);
      cfg(1'h1, 16'h0001 << bt[i], 1'h0);
      `CHK("visible", 16'h0001 << bt[i], periph_visible)
      `CHK("limited", (i < 2), ext_limited)
      acc(ad, 4'h0, t, 1'h0);
      `CHK("waits", 2'h2, sel.waits)
      `CHK("demux", 1'h1, sel.demux)
      acc(ad, 4'h4, t, 1'h1);
      cfg(1'h1, 16'h0000, 1'h0);
      acc(ad, 4'h0, xad_pkg::XAD_T_EXT, 1'h0);
    end
    cfg(1'h1, 16'h000C, 1'h0);
    acc(24'h00_E000, 4'h8, xad_pkg::XAD_T_SRAM, 1'h0);
    `CHK("waits", 2'h0, sel.waits)
    acc(24'h00_E7FF, 4'h4, xad_pkg::XAD_T_SRAM, 1'h0);
    acc(24'h00_E800, 4'h0, xad_pkg::XAD_T_EXT, 1'h0);
    acc(24'h00_E002, 4'h2, xad_pkg::XAD_T_SRAM, 1'h1);
    acc(24'h00_E004, 4'h1, xad_pkg::XAD_T_SRAM, 1'h1);
    acc(24'h09_0000, 4'h0, xad_pkg::XAD_T_LRAM, 1'h0);
    acc(24'h09_5FFF, 4'h4, xad_pkg::XAD_T_LRAM, 1'h0);
    `CHK("fold", 24'h00_1FFF, sel.addr)
    acc(24'h09_E000, 4'h0, xad_pkg::XAD_T_EXT, 1'h0);
    // move the large ram to the next segment
    @(posedge clk);
    #1;
    lrw_load = 1'h1;
    lrw_value = 8'h0A;
    @(posedge clk);
    #1;
    lrw_load = 1'h0;
    `CHK("window", 8'h0A, large_ram_window_select)
    acc(24'h0A_C010, 4'h0, xad_pkg::XAD_T_LRAM, 1'h0);
    acc(24'h09_0000, 4'h0, xad_pkg::XAD_T_EXT, 1'h0);
    cfg(1'h1, 16'h0004, 1'h0);
    acc(24'h0A_0000, 4'h0, xad_pkg::XAD_T_EXT, 1'h0);
    cfg(1'h0, 16'h000C, 1'h0);
    `CHK("visible", 16'h0000, periph_visible)
    acc(24'h00_E000, 4'h0, xad_pkg::XAD_T_EXT, 1'h0);
    acc(24'h0A_0000, 4'h0, xad_pkg::XAD_T_EXT, 1'h0);
    acc(24'h00_7FFF, 4'h4, xad_pkg::XAD_T_FLASH, 1'h0);
    acc(24'h01_8000, 4'h0, xad_pkg::XAD_T_FLASH, 1'h0);
    acc(24'h02_FFFE, 4'h0, xad_pkg::XAD_T_FLASH, 1'h0);
    acc(24'h03_0000, 4'h0, xad_pkg::XAD_T_RSV, 1'h0);
    acc(24'h04_FFFF, 4'h4, xad_pkg::XAD_T_RSV, 1'h0);
    acc(24'h00_8000, 4'h0, xad_pkg::XAD_T_EXT, 1'h0);
    cfg(1'h0, 16'h000C, 1'h1);
    acc(24'h00_0000, 4'h0, xad_pkg::XAD_T_TFL, 1'h0);
    acc(24'h00_2000, 4'h0, xad_pkg::XAD_T_FLASH, 1'h0);
    acc(24'h12_3456, 4'h0, xad_pkg::XAD_T_EXT, 1'h0);
    `CHK("ext_win", 3'h1, sel.ext_win)
    acc(24'h60_0000, 4'h0, xad_pkg::XAD_T_EXT, 1'h0);
    `CHK("ext_win", 3'h0, sel.ext_win)
    cfg(1'h1, 16'h0001, 1'h0);
    acc(24'h4F_FFFE, 4'h0, xad_pkg::XAD_T_EXT, 1'h0);
    acc(24'h50_0000, 4'h0, xad_pkg::XAD_T_EXT, 1'h1);
    tally_and_finish();
  end
endmodule
